/* logic/prd_pkg.sv */
// Package: constants and carrier types for the pump duty sequencer
package prd_pkg;
  // Duty strategies selected by duty_mode_select
  localparam logic [7:0] DUTY_FIX_ASSIST = 8'h32;
  localparam logic [7:0] DUTY_FIX_BACKUP = 8'h33;
  localparam logic [7:0] DUTY_ALT_ASSIST = 8'h34;
  localparam logic [7:0] DUTY_ALT_BACKUP = 8'h35;
  localparam logic [7:0] DUTY_SR_ASSIST = 8'h36;
  localparam logic [7:0] DUTY_SR_BACKUP = 8'h37;
  localparam logic [7:0] DUTY_FIFO = 8'h38;
  localparam logic [1:0] RELAY_OP_SETPOINT = 2'h2;
  localparam logic [1:0] POL_NORM_OPEN = 2'h2;
  localparam logic [1:0] POL_NORM_CLOSED = 2'h3;
  // Overflow actions
  localparam logic [1:0] OVF_NONE = 2'h0;
  localparam logic [1:0] OVF_VALVE = 2'h1;
  localparam logic [1:0] OVF_STOP = 2'h2;
  localparam logic [1:0] OVF_START_ALL = 2'h3;
  // Times and the cycle counts derived from the 125 MHz clock
  localparam int CLK_KHZ = 125000;
  localparam int RUNON_MS = 10000;
  localparam int FLUSH_MS = 5000;
  localparam int RATE_STEP_MS = 1000;
  localparam int RUNON_CYC = RUNON_MS * CLK_KHZ;
  localparam int FLUSH_CYC = FLUSH_MS * CLK_KHZ;
  localparam int RATE_STEP_CYC = RATE_STEP_MS * CLK_KHZ;
  localparam int HOUR_TICK_CYC = 1000 * CLK_KHZ;
  // Reset values
  localparam logic [1:0] ROT_RESET = 2'h0;
  localparam int NPUMP_DEF = 3;
  // Configuration carried as one group
  typedef struct packed {
    logic [7:0] dutyModeSelect;
    logic [1:0] relayOpMode;
    logic rateControlEnable;
    logic pumpsFill;
    logic useUnderflow;
    logic [1:0] ovfAction;
    logic [15:0] fillingRateSetpoint;
    logic [15:0] emptyingRateSetpoint;
    logic [15:0] costOffset;
    logic [7:0] runOnInterval;
    logic [7:0] flushInterval;
  } prd_cfg_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_RUNON = 3'b100
  } prd_state_e;
endpackage : prd_pkg

/* logic/prd_pump_relay_duty_sequencer.sv */
// Pump duty sequencer: setpoints to relays, interlocks, run-on, flush, overflow
`timescale 1ns/1ns
module prd_pump_relay_duty_sequencer #(
  parameter int NPUMP = prd_pkg::NPUMP_DEF,
  parameter int RUNON_CYCLES = prd_pkg::RUNON_CYC,
  parameter int FLUSH_CYCLES = prd_pkg::FLUSH_CYC,
  parameter int RATE_STEP_CYCLES = prd_pkg::RATE_STEP_CYC,
  parameter int HOUR_TICK_CYCLES = prd_pkg::HOUR_TICK_CYC
) (
  input wire logic mclk, // 125 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire prd_pkg::prd_cfg_s cfg, // Static configuration
  input wire logic [15:0] level, // Measured level
  input wire logic signed [15:0] levelRate, // Level change rate
  input wire logic [NPUMP-1:0][15:0] onLevel, // On setpoints by index
  input wire logic [NPUMP-1:0][15:0] offLevel, // Off setpoints, staggered for FIFO
  input wire logic [NPUMP-1:0][7:0] runRatio, // Per pump run ratio
  input wire logic [NPUMP-1:0] pumpGroup, // Group of each pump
  input wire logic [NPUMP-1:0] faultContact, // Raw fault contacts
  input wire logic [NPUMP-1:0][1:0] inputPolarityCfg, // Polarity per fault contact
  input wire logic [NPUMP-1:0] autoContact, // Raw auto/manual contacts
  input wire logic [NPUMP-1:0] failReset, // Clears latched failure
  input wire logic highCostPeriod, // Time-of-day high cost window
  input wire logic overflowHighAlarm, // Overflow alarm
  input wire logic underflowLowAlarm, // Underflow alarm
  output logic [NPUMP-1:0] relay, // Pump relay contacts, 1 closed
  output logic [NPUMP-1:0] inputState, // Corrected fault input state
  output logic [NPUMP-1:0] autoAllocation, // 1 auto, 0 manual
  output logic [NPUMP-1:0] pumpFailedStatus, // Latched pump failure
  output logic flushValve, // Flush valve drive
  output logic overflowValve // Overflow valve drive
);
  localparam int RW = $clog2(NPUMP);
  localparam int CW = $clog2(NPUMP + 1);
  typedef logic [RW-1:0] prd_idx_t;
  typedef logic [CW-1:0] prd_cnt_t;

  // Run-on needs two cycles at least so its hold check has something to watch
  if (NPUMP < 2 || NPUMP > 8 || RUNON_CYCLES < 2 || FLUSH_CYCLES < 1 || RATE_STEP_CYCLES < 1
      || HOUR_TICK_CYCLES < 1)
  begin : g_param_check
    $error("prd: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Wrap a pump index; rotation is modulo the pump count NPUMP
  function automatic prd_idx_t prd_wrap(input int v);
    prd_wrap = prd_idx_t'(v % NPUMP);
  endfunction : prd_wrap

  // Start rank of pump p in its group, counting from the lead, skipping unavailable pumps
  function automatic prd_cnt_t prd_rank(input prd_idx_t lead, input int p, input logic [NPUMP-1:0] mask);
    prd_cnt_t n;
    prd_rank = prd_cnt_t'(NPUMP);
    n = '0;
    for (int k = 0; k < NPUMP; k++)
    begin
      if (mask[prd_wrap(int'(lead) + k)])
      begin
        if (prd_wrap(int'(lead) + k) == prd_idx_t'(p))
          prd_rank = n;
        n = prd_cnt_t'(n + 1'b1);
      end
    end
  endfunction : prd_rank

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  prd_pkg::prd_state_e state, next_state;
  prd_cnt_t demand, next_demand;
  prd_idx_t rot [2];
  prd_idx_t next_rot [2];
  logic [7:0] startCnt, next_startCnt;
  logic [31:0] timer, next_timer;
  logic [31:0] flushTmr, next_flushTmr;
  logic [31:0] hourTmr, next_hourTmr;
  logic [NPUMP-1:0][23:0] runHours, next_runHours;
  logic [NPUMP-1:0] next_relay, next_inputState, next_autoAllocation, next_failed;
  logic next_flushValve, next_overflowValve;

  // Comparisons against setpoints
  logic [NPUMP-1:0] avail, onHit, offHit;
  prd_cnt_t onCnt, offCnt;
  logic alarm, rateMet, isAlt, isSr, isFifo, isBackup, isFixed, runOnDue, flushDue;

  // Level compares; high cost lowers the on points to cut head
  always_comb
  begin
    onCnt = '0;
    offCnt = '0;
    for (int k = 0; k < NPUMP; k++)
    begin
      onHit[k] = level >= (highCostPeriod ? onLevel[k] - cfg.costOffset : onLevel[k]);
      offHit[k] = level <= offLevel[k];
      onCnt = onCnt + prd_cnt_t'(onHit[k]);
      offCnt = offCnt + prd_cnt_t'(offHit[k]);
    end
    avail = ~pumpFailedStatus & autoAllocation;
    alarm = cfg.useUnderflow ? underflowLowAlarm : overflowHighAlarm;
    rateMet = cfg.pumpsFill ? (levelRate >= $signed(cfg.fillingRateSetpoint))
                            : (-levelRate >= $signed(cfg.emptyingRateSetpoint));
    isFixed = cfg.dutyModeSelect == prd_pkg::DUTY_FIX_ASSIST || cfg.dutyModeSelect == prd_pkg::DUTY_FIX_BACKUP;
    isAlt = cfg.dutyModeSelect == prd_pkg::DUTY_ALT_ASSIST || cfg.dutyModeSelect == prd_pkg::DUTY_ALT_BACKUP;
    isSr = cfg.dutyModeSelect == prd_pkg::DUTY_SR_ASSIST || cfg.dutyModeSelect == prd_pkg::DUTY_SR_BACKUP;
    isFifo = cfg.dutyModeSelect == prd_pkg::DUTY_FIFO;
    isBackup = cfg.dutyModeSelect == prd_pkg::DUTY_FIX_BACKUP || cfg.dutyModeSelect == prd_pkg::DUTY_ALT_BACKUP
               || cfg.dutyModeSelect == prd_pkg::DUTY_SR_BACKUP;
    runOnDue = cfg.runOnInterval != 8'h00 && startCnt % cfg.runOnInterval == 8'h00;
    flushDue = cfg.flushInterval != 8'h00 && startCnt % cfg.flushInterval == 8'h00;
  end

  // ----------------------------------------------------------------
  // Interlock inputs
  // ----------------------------------------------------------------
  // Polarity correction and latched failure; a new fault beats a reset
  always_comb
  begin
    for (int p = 0; p < NPUMP; p++)
    begin
      next_inputState[p] = (inputPolarityCfg[p] == prd_pkg::POL_NORM_CLOSED) ? ~faultContact[p]
                                                                             : faultContact[p];
      next_autoAllocation[p] = autoContact[p];
      next_failed[p] = inputState[p] | (pumpFailedStatus[p] & ~failReset[p]);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inputState <= '0;
      autoAllocation <= '1;
      pumpFailedStatus <= '0;
    end
    else
    begin
      inputState <= next_inputState;
      autoAllocation <= next_autoAllocation;
      pumpFailedStatus <= next_failed;
    end
  end

  // ----------------------------------------------------------------
  // Level cycle sequencer
  // ----------------------------------------------------------------
  // Demand grows with setpoints (or step by step on rate); cycle end rotates the lead
  always_comb
  begin
    next_state = state;
    next_demand = demand;
    next_rot = rot;
    next_startCnt = startCnt;
    next_timer = timer;
    next_flushTmr = flushTmr == 32'h0 ? 32'h0 : flushTmr - 32'h1;
    next_hourTmr = hourTmr == 32'h0 ? 32'(HOUR_TICK_CYCLES - 1) : hourTmr - 32'h1;
    next_runHours = runHours;
    for (int p = 0; p < NPUMP; p++)
      if (relay[p] && hourTmr == 32'h0)
        next_runHours[p] = runHours[p] + 24'h1;
    case (state)
      prd_pkg::ST_IDLE:
      begin
        if (onCnt != '0)
        begin
          next_state = prd_pkg::ST_RUN;
          next_demand = cfg.rateControlEnable ? prd_cnt_t'(1) : onCnt;
          next_startCnt = startCnt + 8'h1;
          next_timer = 32'(RATE_STEP_CYCLES - 1);
        end
      end
      prd_pkg::ST_RUN:
      begin
        if (cfg.rateControlEnable)
        begin
          next_timer = timer == 32'h0 ? 32'(RATE_STEP_CYCLES - 1) : timer - 32'h1;
          if (timer == 32'h0 && !rateMet && demand < prd_cnt_t'(NPUMP))
            next_demand = demand + prd_cnt_t'(1);
        end
        else if (onCnt > demand)
          next_demand = onCnt;
        if ((isFifo && offCnt >= demand) || (!isFifo && offHit[0]))
        begin
          if (runOnDue && !isFifo)
          begin
            next_state = prd_pkg::ST_RUNON;
            next_timer = 32'(RUNON_CYCLES - 1);
          end
          else
            next_state = prd_pkg::ST_IDLE;
        end
      end
      prd_pkg::ST_RUNON:
      begin
        next_timer = timer - 32'h1;
        if (timer == 32'h0)
          next_state = prd_pkg::ST_IDLE;
      end
      default:
        next_state = prd_pkg::ST_IDLE;
    endcase
    // Cycle end: advance each group's lead separately
    if (state != prd_pkg::ST_IDLE && next_state == prd_pkg::ST_IDLE)
    begin
      next_demand = '0;
      if (flushDue)
        next_flushTmr = 32'(FLUSH_CYCLES);
      for (int g = 0; g < 2; g++)
      begin
        next_rot[g] = prd_wrap(int'(rot[g]) + 1);
        if (isSr)
        begin
          // Lead is the pump furthest behind its share: least hours per ratio
          for (int p = NPUMP - 1; p >= 0; p--)
            if (pumpGroup[p] == g[0] && avail[p] && runRatio[p] != 8'h00)
              if (runHours[p] * runRatio[next_rot[g]] <= runHours[next_rot[g]] * runRatio[p]
                  || !avail[next_rot[g]] || pumpGroup[next_rot[g]] != g[0])
                next_rot[g] = prd_idx_t'(p);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= prd_pkg::ST_IDLE;
      demand <= '0;
      rot[0] <= prd_idx_t'(prd_pkg::ROT_RESET);
      rot[1] <= prd_idx_t'(prd_pkg::ROT_RESET);
      startCnt <= 8'h00;
      timer <= 32'h0;
      flushTmr <= 32'h0;
      hourTmr <= 32'h0;
      runHours <= '0;
    end
    else
    begin
      state <= next_state;
      demand <= next_demand;
      rot <= next_rot;
      startCnt <= next_startCnt;
      timer <= next_timer;
      flushTmr <= next_flushTmr;
      hourTmr <= next_hourTmr;
      runHours <= next_runHours;
    end
  end

  // ----------------------------------------------------------------
  // Relay mapping
  // ----------------------------------------------------------------
  // Rank of each pump from its group's lead (pump index in fixed modes); backup closes only the pump ranked demand - 1, except under an OVF_START_ALL alarm
  prd_cnt_t rank [NPUMP];
  always_comb
  begin
    for (int p = 0; p < NPUMP; p++)
    begin
      rank[p] = isFixed ? prd_cnt_t'(p) : prd_rank(rot[pumpGroup[p]], p, avail & ~(pumpGroup ^ {NPUMP{pumpGroup[p]}}));
      if (state == prd_pkg::ST_IDLE)
        next_relay[p] = 1'b0;
      else if (isBackup)
        next_relay[p] = rank[p] == demand - prd_cnt_t'(1);
      else if (isFifo)
        next_relay[p] = rank[p] < demand && rank[p] >= offCnt;
      else
        next_relay[p] = rank[p] < demand;
      next_relay[p] = next_relay[p] & avail[p];
      if (alarm && cfg.ovfAction == prd_pkg::OVF_STOP)
        next_relay[p] = 1'b0;
      else if (alarm && cfg.ovfAction == prd_pkg::OVF_START_ALL)
        next_relay[p] = avail[p];
      if (cfg.relayOpMode != prd_pkg::RELAY_OP_SETPOINT)
        next_relay[p] = 1'b0;
    end
    next_flushValve = next_flushTmr != 32'h0;
    next_overflowValve = alarm && cfg.ovfAction == prd_pkg::OVF_VALVE;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      relay <= '0;
      flushValve <= 1'b0;
      overflowValve <= 1'b0;
    end
    else
    begin
      relay <= next_relay;
      flushValve <= next_flushValve;
      overflowValve <= next_overflowValve;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  relay_op_gate_a: assert property (cfg.relayOpMode != prd_pkg::RELAY_OP_SETPOINT |=> relay == '0)
    else $error("relay closed outside setpoint mode");
  backup_single_a: assert property (isBackup && $stable(cfg) |=> $onehot0(relay))
    else $error("backup mode closed two relays");
  rotate_step_a: assert property (state == prd_pkg::ST_RUN && next_state == prd_pkg::ST_IDLE && !isSr
                                  |=> rot[0] == prd_wrap(int'($past(rot[0])) + 1))
    else $error("rotation did not advance by one");
  fail_latch_a: assert property (inputState != '0
                                 |=> (pumpFailedStatus & $past(inputState)) == $past(inputState))
    else $error("fault not latched");
  failed_off_a: assert property (pumpFailedStatus != '0 |=> (relay & $past(pumpFailedStatus)) == '0)
    else $error("failed pump relay closed");
  polarity_nc_a: assert property (inputPolarityCfg[0] == prd_pkg::POL_NORM_CLOSED && faultContact[0]
                                  |=> !inputState[0])
    else $error("normally closed polarity wrong");
  auto_sense_a: assert property (autoContact[0] |=> autoAllocation[0])
    else $error("auto allocation sense wrong");
  ovf_stop_a: assert property (alarm && cfg.ovfAction == prd_pkg::OVF_STOP |=> relay == '0)
    else $error("stop action left relay closed");
  idle_open_a: assert property (state == prd_pkg::ST_IDLE && !alarm |=> relay == '0)
    else $error("relay closed with no demand");
  runon_hold_a: assert property (state == prd_pkg::ST_RUN && next_state == prd_pkg::ST_RUNON
                                 |=> state == prd_pkg::ST_RUNON [*2])
    else $error("run-on ended early");
endmodule : prd_pump_relay_duty_sequencer

/* verification/prd_pump_field.sv */
// Field model: pump fault contacts and auto/manual switches behind the sequencer
`timescale 1ns/1ns
module prd_pump_field #(
  parameter int NPUMP = 3
) (
  input wire logic [NPUMP-1:0][1:0] polarity, // Wiring of each fault contact
  input wire logic [NPUMP-1:0] faultCmd, // Bench asks a pump to fault
  input wire logic [NPUMP-1:0] manualCmd, // Bench turns a switch to manual
  output logic [NPUMP-1:0] faultContact, // Raw fault contacts
  output logic [NPUMP-1:0] autoContact // Raw auto/manual contacts
);
  // ---------------------------------
  // Contact wiring
  // ---------------------------------
  // Normally closed wiring opens on a fault, so a broken wire reads as a fault
  always_comb
  begin
    for (int i = 0; i < NPUMP; i++)
    begin
      if (polarity[i] == prd_pkg::POL_NORM_CLOSED)
        faultContact[i] = ~faultCmd[i];
      else
        faultContact[i] = faultCmd[i];
    end
  end
  // Switch contact is closed while the pump is left in automatic
  assign autoContact = ~manualCmd;
endmodule : prd_pump_field

/* verification/tb.sv */
// Testbench: scenario tasks for the pump duty sequencer
`timescale 1ns/1ns
module tb;
  // ---------------------------------
  // Stimulus and observed signals
  // ---------------------------------
  logic mclk;
  logic rstN;
  prd_pkg::prd_cfg_s cfg;
  logic [15:0] level;
  logic signed [15:0] levelRate;
  logic [2:0][15:0] onLevel;
  logic [2:0][15:0] offLevel;
  logic [2:0][7:0] runRatio;
  logic [2:0] pumpGroup;
  logic [2:0][1:0] polCfg;
  logic [2:0] faultCmd, manualCmd, failReset;
  logic highCost, ovfAlarm, udfAlarm;
  logic [2:0] faultContact, autoContact, relay, inputState, autoAllocation, failed;
  logic flushValve, overflowValve;
  int numErrors = 0;
  int nTests = 0;
  int cycles = 0;
  // Expected relays by level cycle and setpoint reached
  logic [2:0] altAssist [3][3] = '{'{3'h1, 3'h3, 3'h7}, '{3'h2, 3'h6, 3'h7}, '{3'h4, 3'h5, 3'h7}};
  logic [2:0] altBackup [3][3] = '{'{3'h1, 3'h2, 3'h4}, '{3'h2, 3'h4, 3'h1}, '{3'h4, 3'h1, 3'h2}};

  // Short counts keep the run-on, flush and rate waits to a few dozen cycles
  prd_pump_relay_duty_sequencer #(.NPUMP(3), .RUNON_CYCLES(20), .FLUSH_CYCLES(10), .RATE_STEP_CYCLES(5),
    .HOUR_TICK_CYCLES(4)) dut (.mclk(mclk), .rst_n(rstN), .cfg(cfg), .level(level), .levelRate(levelRate),
    .onLevel(onLevel), .offLevel(offLevel), .runRatio(runRatio), .pumpGroup(pumpGroup),
    .faultContact(faultContact), .inputPolarityCfg(polCfg), .autoContact(autoContact), .failReset(failReset),
    .highCostPeriod(highCost), .overflowHighAlarm(ovfAlarm), .underflowLowAlarm(udfAlarm), .relay(relay),
    .inputState(inputState), .autoAllocation(autoAllocation), .pumpFailedStatus(failed),
    .flushValve(flushValve), .overflowValve(overflowValve));

  prd_pump_field #(.NPUMP(3)) field (.polarity(polCfg), .faultCmd(faultCmd), .manualCmd(manualCmd),
    .faultContact(faultContact), .autoContact(autoContact));

  // ---------------------------------
  // Clock, timeout and helpers
  // ---------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Whole run needs about 500 cycles; a hang is cut well after that
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      numErrors++;
      $display("BAD t=%0t timeout", $time);
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask : step

  task automatic chk_vec(input logic [2:0] got, input logic [2:0] exp, input string what);
    nTests++;
    if (got !== exp)
    begin
      numErrors++;
      $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_vec

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_vec({2'h0, got}, {2'h0, exp}, what);
  endtask : chk_bit

  function automatic logic [15:0] onAt(input int k);
    return 16'h0078 + 16'(k) * 16'h0064;
  endfunction : onAt

  // Relay answers two cycles after the level; four leaves margin
  task automatic lvl(input logic [15:0] v, input logic [2:0] exp);
    level = v;
    step(4);
    chk_vec(relay, exp, "relay");
  endtask : lvl

  task automatic restart(input logic [7:0] mode);
    cfg = '0;
    cfg.dutyModeSelect = mode;
    cfg.relayOpMode = prd_pkg::RELAY_OP_SETPOINT;
    level = 16'h0014;
    levelRate = 16'sh0000;
    {highCost, ovfAlarm, udfAlarm, faultCmd, manualCmd, failReset} = '0;
    rstN = 1'b0;
    step(2);
    rstN = 1'b1;
    step(1);
  endtask : restart

  // ---------------------------------
  // Scenarios
  // ---------------------------------
  task automatic test_fixed;
    restart(prd_pkg::DUTY_FIX_ASSIST);
    for (int k = 0; k < 3; k++) lvl(onAt(k), altAssist[0][k]);
    lvl(16'h0014, 3'h0);
    restart(prd_pkg::DUTY_FIX_BACKUP);
    for (int k = 0; k < 3; k++) lvl(onAt(k), altBackup[0][k]);
    lvl(16'h0014, 3'h0);
    restart(prd_pkg::DUTY_FIX_ASSIST);
    cfg.relayOpMode = 2'h1;
    lvl(onAt(2), 3'h0);
    $display("fixed modes done");
  endtask : test_fixed

  // Four level cycles so the rotation wraps back to the first pump
  task automatic test_alt(input logic [7:0] mode, input logic [2:0] tbl [3][3]);
    restart(mode);
    for (int c = 0; c < 4; c++)
    begin
      for (int k = 0; k < 3; k++) lvl(onAt(k), tbl[c % 3][k]);
      lvl(16'h0014, 3'h0);
    end
    $display("alternate mode %h done", mode);
  endtask : test_alt

  task automatic test_fifo;
    restart(prd_pkg::DUTY_FIFO);
    lvl(onAt(0), 3'h1);
    lvl(onAt(2), 3'h7);
    lvl(16'h002d, 3'h6);
    lvl(16'h0023, 3'h4);
    lvl(16'h0019, 3'h0);
    $display("fifo done");
  endtask : test_fifo

  task automatic test_interlocks;
    restart(prd_pkg::DUTY_FIX_ASSIST);
    for (int p = 2; p < 4; p++)
    begin
      polCfg = {3{p[1:0]}};
      step(3);
      chk_vec(inputState, 3'h0, "state normal");
      faultCmd = 3'h2;
      step(3);
      chk_vec(inputState, 3'h2, "state fault");
      chk_vec(failed, 3'h2, "failed latch");
      faultCmd = 3'h0;
      level = onAt(2);
      step(4);
      chk_vec(relay & 3'h2, 3'h0, "failed pump");
      level = 16'h0014;
      chk_vec(failed, 3'h2, "failed held");
      failReset = 3'h2;
      step(3);
      failReset = 3'h0;
      step(1);
      chk_vec(failed, 3'h0, "failed cleared");
    end
    manualCmd = 3'h4;
    step(3);
    chk_vec(autoAllocation, 3'h3, "manual");
    level = onAt(2);
    step(4);
    chk_vec(relay & 3'h4, 3'h0, "manual pump");
    manualCmd = 3'h0;
    step(3);
    chk_vec(autoAllocation, 3'h7, "auto");
    $display("interlocks done");
  endtask : test_interlocks

  task automatic test_overflow;
    logic [2:0] expRelay [4] = '{3'h1, 3'h1, 3'h0, 3'h7};
    for (int a = 1; a < 4; a++)
    begin
      restart(prd_pkg::DUTY_FIX_ASSIST);
      cfg.ovfAction = a[1:0];
      lvl(onAt(0), 3'h1);
      ovfAlarm = 1'b1;
      step(4);
      chk_vec(relay, expRelay[a], "overflow relay");
      chk_bit(overflowValve, a == 1, "overflow valve");
    end
    // Underflow source: only the low alarm may drive the action
    restart(prd_pkg::DUTY_FIX_ASSIST);
    cfg.useUnderflow = 1'b1;
    cfg.ovfAction = prd_pkg::OVF_VALVE;
    udfAlarm = 1'b1;
    step(3);
    chk_bit(overflowValve, 1'b1, "underflow valve");
    udfAlarm = 1'b0;
    ovfAlarm = 1'b1;
    step(3);
    chk_bit(overflowValve, 1'b0, "underflow source");
    $display("overflow done");
  endtask : test_overflow

  task automatic test_rate_cost;
    restart(prd_pkg::DUTY_ALT_ASSIST);
    cfg.rateControlEnable = 1'b1;
    cfg.emptyingRateSetpoint = 16'h0010;
    levelRate = -16'sh0020;
    level = onAt(0);
    step(30);
    chk_vec(relay, 3'h1, "rate met");
    levelRate = 16'sh0000;
    step(30);
    chk_vec(relay, 3'h7, "rate unmet");
    restart(prd_pkg::DUTY_FIX_ASSIST);
    cfg.costOffset = 16'h0030;
    lvl(16'h0050, 3'h0);
    highCost = 1'b1;
    lvl(16'h0050, 3'h1);
    $display("rate and cost done");
  endtask : test_rate_cost

  task automatic test_runon_flush;
    int high;
    restart(prd_pkg::DUTY_FIX_ASSIST);
    cfg.runOnInterval = 8'h01;
    cfg.flushInterval = 8'h01;
    high = 0;
    lvl(onAt(0), 3'h1);
    // Run-on holds the pump past the off point; the flush starts only when the cycle ends
    lvl(16'h0014, 3'h1);
    for (int i = 0; i < 40; i++)
    begin
      step(1);
      if (flushValve === 1'b1) high++;
    end
    chk_bit(high == 10, 1'b1, "flush length");
    chk_vec(relay, 3'h0, "run-on end");
    $display("run-on and flush done");
  endtask : test_runon_flush

  // Pump 2 alone in group 1; group 0 rotates between pumps 0 and 1
  task automatic test_groups_ratio;
    pumpGroup = 3'h4;
    restart(prd_pkg::DUTY_ALT_ASSIST);
    lvl(onAt(0), 3'h5);
    lvl(16'h0014, 3'h0);
    lvl(onAt(0), 3'h6);
    lvl(16'h0014, 3'h0);
    pumpGroup = 3'h0;
    // Pump 1 has no share, so pump 2 must lead once pump 0 has run hours
    runRatio = {8'h32, 8'h00, 8'h19};
    for (int m = 0; m < 2; m++)
    begin
      restart(m == 0 ? prd_pkg::DUTY_SR_ASSIST : prd_pkg::DUTY_SR_BACKUP);
      lvl(onAt(0), 3'h1);
      step(8);
      lvl(16'h0014, 3'h0);
      lvl(onAt(0), 3'h4);
      lvl(onAt(1), m == 0 ? 3'h5 : 3'h1);
    end
    $display("groups and ratio done");
  endtask : test_groups_ratio

  // ---------------------------------
  // Main sequence
  // ---------------------------------
  initial
  begin
    rstN = 1'b0;
    cfg = '0;
    {level, levelRate, highCost, ovfAlarm, udfAlarm} = '0;
    onLevel = {16'h012c, 16'h00c8, 16'h0064};
    offLevel = {16'h001e, 16'h0028, 16'h0032};
    runRatio = {8'h32, 8'h19, 8'h19};
    pumpGroup = 3'h0;
    polCfg = {3{prd_pkg::POL_NORM_OPEN}};
    {faultCmd, manualCmd, failReset} = '0;
    step(8);
    rstN = 1'b1;
    step(1);
    chk_vec(relay, 3'h0, "reset relay");
    chk_vec(autoAllocation, 3'h7, "reset auto");
    chk_vec({failed[0], flushValve, overflowValve}, 3'h0, "reset outputs");
    test_fixed();
    test_alt(prd_pkg::DUTY_ALT_ASSIST, altAssist);
    test_alt(prd_pkg::DUTY_ALT_BACKUP, altBackup);
    test_fifo();
    test_interlocks();
    test_overflow();
    test_rate_cost();
    test_runon_flush();
    test_groups_ratio();
    print_verdict();
  end
endmodule : tb
